// ---- dv/flash_env_model.sv ----
// Purpose: ram and flash array seen by the self-write sequencer
// Assumes: ram answers one cycle after a read strobe
// Notes: failOps makes every flash operation report an error
`timescale 1ns/10ps
module flash_env_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire flash_sw_pkg::ram_req_s ramReq,
    output logic [7:0] ramRdata,
    input wire logic flashReq,
    input wire flash_sw_pkg::flash_req_s flashCmd,
    output logic flashAck,
    output logic flashErr,
    input wire logic failOps
);
    import flash_sw_pkg::*;
    logic [7:0] ram [0:65535];
    logic [7:0] rom [0:65535];
    int waitCnt;
    int waitLim;
    initial
    begin
        foreach (rom[i]) rom[i] = 8'hff;
        ramRdata = 8'h00;
        flashAck = 1'b0;
        flashErr = 1'b0;
        waitCnt = 0;
        waitLim = 2;
    end
    // idle cycles invert the previous output so a byte one cycle stale never passes
    always @(posedge ref_clk)
    begin
        ramRdata <= ramReq.re ? ram[ramReq.addr] : ~ramRdata;
        if (ramReq.we) ram[ramReq.addr] <= ramReq.wdata;
        flashAck <= 1'b0;
        flashErr <= 1'b0;
        if (!rstn) waitCnt <= 0;
        else if (flashReq && !flashAck)
        begin
            waitCnt <= waitCnt + 1;
            if (waitCnt >= waitLim)
            begin
                flashAck <= 1'b1;
                flashErr <= failOps;
                waitCnt <= 0;
                waitLim <= $urandom_range(0, 5);
                if (flashCmd.cmd == FC_PROGRAM && !failOps) rom[flashCmd.addr] <= flashCmd.wdata;
            end
        end
    end
endmodule : flash_env_model

// ---- dv/flash_self_write_control_asserts.sv ----
// Purpose: port checks for the self-write controller
// Assumes: one clock, asynchronous active-low reset
// Notes: byte-write length is unbounded here, checked by the bench
`timescale 1ns/10ps
module flash_self_write_control_asserts (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire flash_sw_pkg::sfr_bus_s sfrBus,
    input wire logic [7:0] sfrRdata,
    input wire logic vppSense,
    input wire logic selfWriteMode,
    input wire logic callReq,
    input wire logic [7:0] funcNum,
    input wire logic callDone,
    input wire logic busy,
    input wire logic [7:0] statusB,
    input wire flash_sw_pkg::ram_req_s ramReq,
    input wire logic flashReq,
    input wire flash_sw_pkg::flash_req_s flashCmd,
    input wire logic flashAck,
    input wire logic flashErr
);
    import flash_sw_pkg::*;
    wire logic hit = sfrBus.addr == MODE_CTRL_ADDR;
    wire logic take = callReq && !busy;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    AST_BYTE_WR: assert property (
        sfrBus.wr && hit |=> selfWriteMode == $past(sfrBus.wdata[0]))
        else $error("byte write missed mode bit");
    AST_BIT_WR: assert property (
        sfrBus.bitWr && !sfrBus.wr && hit && sfrBus.bitSel == 3'h0
        |=> selfWriteMode == $past(sfrBus.wdata[0])) else $error("bit write missed");
    AST_MODE_HOLD: assert property (
        !sfrBus.wr && !sfrBus.bitWr |=> $stable(selfWriteMode))
        else $error("mode changed without write");
    AST_VPP_READ: assert property (
        sfrBus.rd && hit && !sfrBus.wr && !sfrBus.bitWr
        |=> sfrRdata[2] == $past(vppSense, 2) && sfrRdata[0] == selfWriteMode)
        else $error("read data wrong");
    AST_RD_IDLE: assert property (
        !(sfrBus.rd && hit) |=> sfrRdata == 8'h00) else $error("read data not zero");
    AST_DONE_PULSE: assert property (
        callDone |=> !callDone) else $error("done longer than one cycle");
    AST_NORMAL: assert property (
        take && !selfWriteMode |=> callDone && statusB == ST_PARAM && !ramReq.re && !ramReq.we)
        else $error("normal mode call not refused");
    AST_INIT: assert property (
        take && selfWriteMode && funcNum == FN_INIT |=> callDone && $stable(statusB))
        else $error("init call wrong");
    AST_FL_HOLD: assert property (
        flashReq && !flashAck |=> flashReq && $stable(flashCmd)) else $error("flash req moved");
    AST_FL_DROP: assert property (
        flashReq && flashAck |=> !flashReq) else $error("flash req kept after ack");
    AST_DONE_BOUND: assert property (
        take && funcNum != FN_WRITE |-> ##[1:300] callDone) else $error("call never done");
    cover property (callDone && statusB == ST_OK);
    cover property (flashAck && flashErr);
    cover property (take && funcNum == FN_WRITE);
endmodule : flash_self_write_control_asserts
bind flash_self_write_control flash_self_write_control_asserts chk (.ref_clk(ref_clk),
    .rstn(rstn), .sfrBus(sfrBus), .sfrRdata(sfrRdata), .vppSense(vppSense),
    .selfWriteMode(selfWriteMode), .callReq(callReq), .funcNum(funcNum), .callDone(callDone),
    .busy(busy), .statusB(statusB), .ramReq(ramReq), .flashReq(flashReq),
    .flashCmd(flashCmd), .flashAck(flashAck), .flashErr(flashErr));

// ---- dv/test_flash_self_write_control.sv ----
// Purpose: self-checking bench for the self-write controller
// Assumes: entry area and buffers live in the partner ram
// Notes: stimulus changes on the falling edge only
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin numErrors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_flash_self_write_control;
    import flash_sw_pkg::*;
    localparam logic [15:0] BASE = 16'hfc30;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sfr_bus_s sfrBus = '0;
    logic vppSense = 1'b1;
    logic callReq = 1'b0;
    logic [7:0] funcNum = 8'h00;
    logic [15:0] entryPtr = 16'h0000;
    logic failOps = 1'b0;
    logic [7:0] sfrRdata, statusB, ramRdata, writeTime;
    logic selfWriteMode, callDone, busy, flashReq, flashAck, flashErr;
    logic [23:0] eraseTime;
    ram_req_s ramReq;
    flash_req_s flashCmd;
    int numErrors = 0;
    int checks = 0;
    logic [7:0] wt[$] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'h30};
    logic [7:0] fns[$] = '{FN_BLANK, FN_PREWRITE, FN_ERASE, FN_VERIFY};
    logic [7:0] errs[$] = '{ST_BLANK, ST_WRITE, ST_BLANK, ST_VERIFY};
    logic [7:0] q[$];
    logic [23:0] et;
    logic [15:0] st;
    int n;
    always #2 ref_clk = ~ref_clk;
    flash_self_write_control dut (.ref_clk(ref_clk), .rstn(rstn), .sfrBus(sfrBus),
        .sfrRdata(sfrRdata), .vppSense(vppSense), .selfWriteMode(selfWriteMode),
        .callReq(callReq), .funcNum(funcNum), .entryPtr(entryPtr), .callDone(callDone),
        .busy(busy), .statusB(statusB), .ramReq(ramReq), .ramRdata(ramRdata),
        .flashReq(flashReq), .flashCmd(flashCmd), .flashAck(flashAck), .flashErr(flashErr),
        .writeTime(writeTime), .eraseTime(eraseTime));
    flash_env_model env (.ref_clk(ref_clk), .rstn(rstn), .ramReq(ramReq),
        .ramRdata(ramRdata), .flashReq(flashReq), .flashCmd(flashCmd), .flashAck(flashAck),
        .flashErr(flashErr), .failOps(failOps));
    task automatic printVerdict;
        $display("checks %0d errors %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : printVerdict
    task automatic sfrOp(input logic [7:0] d, input logic w, input logic b, input logic r);
        @(negedge ref_clk);
        sfrBus = '{addr: MODE_CTRL_ADDR, wdata: d, wr: w, bitWr: b, bitSel: 3'h0, rd: r};
        @(negedge ref_clk);
        sfrBus = '0;
    endtask : sfrOp
    task automatic put(input logic [4:0] ofs, input logic [7:0] v);
        env.ram[BASE + 16'(ofs)] = v;
    endtask : put
    // status 8'hff means the call reports nothing
    task automatic runCall(input logic [7:0] fn, input logic [7:0] exp);
        int k;
        @(negedge ref_clk);
        // sentinel shows whether the call touched the entry area
        env.ram[BASE] = 8'h5a;
        funcNum = fn;
        callReq = 1'b1;
        @(negedge ref_clk);
        callReq = 1'b0;
        k = 0;
        while (callDone !== 1'b1 && k < 8000)
        begin
            @(negedge ref_clk);
            k++;
        end
        `CHK(callDone, 1'b1)
        `CHK(busy, 1'b0)
        if (exp != 8'hff)
        begin
            `CHK(statusB, exp)
            `CHK(env.ram[BASE], selfWriteMode ? exp : 8'h5a)
        end
    endtask : runCall
    initial
    begin
        #100000;
        numErrors++;
        printVerdict();
    end
    initial
    begin
        void'($urandom(83317));
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (2) @(negedge ref_clk);
        sfrOp(8'h00, 1'b0, 1'b0, 1'b1);
        `CHK(sfrRdata, 8'h0c)
        runCall(FN_SETPARAM, ST_PARAM);
        sfrOp(8'h01, 1'b0, 1'b1, 1'b0);
        vppSense = 1'b0;
        sfrOp(8'h0d, 1'b1, 1'b0, 1'b0);
        sfrOp(8'h00, 1'b0, 1'b0, 1'b1);
        `CHK(sfrRdata, 8'h09)
        vppSense = 1'b1;
        sfrOp(8'h09, 1'b1, 1'b0, 1'b0);
        sfrOp(8'h00, 1'b0, 1'b0, 1'b1);
        `CHK(sfrRdata, 8'h0d)
        entryPtr = BASE;
        runCall(FN_INIT, 8'hff);
        foreach (wt[i])
        begin
            et = 24'($urandom_range(1, 24'hffffff));
            put(OFS_WTIME, wt[i]);
            put(OFS_ETIME, et[7:0]);
            put(OFS_ETIME + 5'h01, et[15:8]);
            put(OFS_ETIME + 5'h02, et[23:16]);
            runCall(FN_SETPARAM, i < 4 ? ST_OK : ST_PARAM);
            if (i < 4) `CHK({writeTime, eraseTime}, {wt[i], et})
            else `CHK(writeTime, wt[3])
        end
        foreach (fns[i])
            for (int a = 0; a < 3; a++)
            begin
                put(OFS_COUNT, 8'(a));
                failOps = (a == 1);
                runCall(fns[i], a == 2 ? ST_PARAM : a == 1 ? errs[i] : ST_OK);
            end
        failOps = 1'b0;
        for (int a = 1; a < 5; a++)
        begin
            put(OFS_COUNT, 8'(a));
            runCall(FN_INFO, a < 4 ? ST_OK : ST_PARAM);
            st = (a == 2) ? AREA0_END : AREA1_END;
            if (a == 1) `CHK(env.ram[BASE + 16'h11], AREA_COUNT)
            if (a == 2 || a == 3) `CHK({env.ram[BASE + 16'h5], env.ram[BASE + 16'h4]}, st)
        end
        for (int k = 0; k < 2; k++)
        begin
            n = k ? 256 : 3;
            st = 16'h0200 + 16'($urandom_range(0, 255));
            put(OFS_START, st[7:0]);
            put(OFS_START + 5'h01, st[15:8]);
            put(OFS_COUNT, 8'(n));
            put(OFS_BUF, 8'h00);
            put(OFS_BUF + 5'h01, 8'hfd);
            for (int j = 0; j < n; j++)
            begin
                env.ram[16'hfd00 + 16'(j)] = 8'($urandom);
                q.push_back(env.ram[16'hfd00 + 16'(j)]);
            end
            runCall(FN_WRITE, ST_OK);
            for (int j = 0; j < n; j++) `CHK(env.rom[st + 16'(j)], q.pop_front())
            `CHK({env.ram[BASE + 16'h3], env.ram[BASE + 16'h2]}, st + 16'(n))
        end
        put(OFS_START, 8'hff);
        put(OFS_START + 5'h01, 8'hef);
        put(OFS_COUNT, 8'h02);
        runCall(FN_WRITE, ST_PARAM);
        runCall(8'h77, ST_PARAM);
        vppSense = 1'b0;
        sfrOp(8'h08, 1'b1, 1'b0, 1'b0);
        sfrOp(8'h00, 1'b0, 1'b0, 1'b1);
        `CHK(sfrRdata, 8'h08)
        printVerdict();
    end
endmodule : test_flash_self_write_control

// ---- hdl/flash_self_write_control.sv ----
// Purpose: self-write mode register and function sequencer for flash
// Assumes: ram answers a read one cycle after ramReq.re is seen
// Notes: flash array timing is done by the flash macro behind flashReq
`timescale 1ns/10ps

module flash_self_write_control #(
    parameter logic [7:0] FW_VERSION = 8'h01, // arbitrary value
    parameter logic [7:0] TOTAL_BLOCKS = 8'h02
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire flash_sw_pkg::sfr_bus_s sfrBus,
    output logic [7:0] sfrRdata,
    input wire logic vppSense,
    output logic selfWriteMode,
    input wire logic callReq,
    input wire logic [7:0] funcNum,
    input wire logic [15:0] entryPtr,
    output logic callDone,
    output logic busy,
    output logic [7:0] statusB,
    output flash_sw_pkg::ram_req_s ramReq,
    input wire logic [7:0] ramRdata,
    output logic flashReq,
    output flash_sw_pkg::flash_req_s flashCmd,
    input wire logic flashAck,
    input wire logic flashErr,
    output logic [7:0] writeTime,
    output logic [23:0] eraseTime
);
    import flash_sw_pkg::*;

    function automatic logic [7:0] errCode(input logic [7:0] fn);
        logic [7:0] code;
        code = ST_WRITE;
        unique case (fn)
            FN_BLANK, FN_ERASE: code = ST_BLANK;
            FN_VERIFY: code = ST_VERIFY;
            default: code = ST_WRITE;
        endcase
        return code;
    endfunction : errCode

    function automatic logic wtOk(input logic [7:0] wt);
        return (wt == WT_1M28) || (wt == WT_2M56) ||
               (wt == WT_5M12) || (wt == WT_8M38);
    endfunction : wtOk

    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic sfrHit;

    assign sfrHit = (sfrBus.addr == MODE_CTRL_ADDR);

    always_comb
    begin
        nxt_mode = mode_ff;
        if (sfrHit && sfrBus.wr)
        begin
            nxt_mode = sfrBus.wdata;
        end
        else if (sfrHit && sfrBus.bitWr)
        begin
            nxt_mode[sfrBus.bitSel] = sfrBus.wdata[0];
        end
        // status bit is the pin level, never what was written
        nxt_mode[VPP_BIT] = vppSense;
        nxt_rdata = (sfrHit && sfrBus.rd) ? mode_ff : 8'h00;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_ff <= MODE_CTRL_RST;
            rdata_ff <= 8'h00;
        end
        else
        begin
            mode_ff <= nxt_mode;
            rdata_ff <= nxt_rdata;
        end
    end

    seq_state_e state_ff;
    seq_state_e nxt_state;
    logic [7:0] pr_ff [0:17];
    logic [7:0] nxt_pr [0:17];
    logic [4:0] idx_ff;
    logic [4:0] nxt_idx;
    logic [15:0] base_ff;
    logic [15:0] nxt_base;
    logic [7:0] func_ff;
    logic [7:0] nxt_func;
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    logic [15:0] cur_ff;
    logic [15:0] nxt_cur;
    logic [15:0] buf_ff;
    logic [15:0] nxt_buf;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic done_ff;
    logic nxt_done;
    ram_req_s ram_ff;
    ram_req_s nxt_ram;
    logic freq_ff;
    logic nxt_freq;
    flash_req_s fcmd_ff;
    flash_req_s nxt_fcmd;
    logic [7:0] wt_ff;
    logic [7:0] nxt_wt;
    logic [23:0] et_ff;
    logic [23:0] nxt_et;
    logic busy_ff;
    logic nxt_busy;

    always_comb
    begin
        logic [7:0] st;
        logic goStore;
        logic [8:0] wcnt;
        logic [16:0] lastAddr;
        logic [15:0] endAddr;
        st = ST_OK;
        goStore = 1'b0;
        wcnt = (pr_ff[OFS_COUNT] == 8'h00) ? MAX_WRITE_BYTES
                                           : {1'b0, pr_ff[OFS_COUNT]};
        lastAddr = {1'b0, pr_ff[OFS_START + 5'h01], pr_ff[OFS_START]}
                   + {8'h00, wcnt} - 17'h00001;
        endAddr = cur_ff + 16'h0001;
        nxt_state = state_ff;
        nxt_pr = pr_ff;
        nxt_idx = idx_ff;
        nxt_base = base_ff;
        nxt_func = func_ff;
        nxt_cnt = cnt_ff;
        nxt_cur = cur_ff;
        nxt_buf = buf_ff;
        nxt_stat = stat_ff;
        nxt_done = 1'b0;
        nxt_ram = '0;
        nxt_freq = freq_ff;
        nxt_fcmd = fcmd_ff;
        nxt_wt = wt_ff;
        nxt_et = et_ff;
        unique case (state_ff)
            S_IDLE:
            begin
                if (callReq)
                begin
                    nxt_func = funcNum;
                    if (!mode_ff[MODE_BIT])
                    begin
                        // normal mode: refused, flash untouched
                        nxt_stat = ST_PARAM;
                        nxt_done = 1'b1;
                    end
                    else if (funcNum == FN_INIT)
                    begin
                        nxt_base = entryPtr;
                        nxt_done = 1'b1;
                    end
                    else
                    begin
                        nxt_idx = OFS_START;
                        nxt_state = S_LOAD_RD;
                    end
                end
            end
            S_LOAD_RD:
            begin
                nxt_ram.addr = base_ff + {11'h000, idx_ff};
                nxt_ram.re = 1'b1;
                nxt_state = S_LOAD_WT;
            end
            S_LOAD_WT:
            begin
                nxt_state = S_LOAD_CAP;
            end
            S_LOAD_CAP:
            begin
                nxt_pr[idx_ff] = ramRdata;
                if (idx_ff == PARAM_LAST)
                begin
                    nxt_state = S_EXEC;
                end
                else
                begin
                    nxt_idx = idx_ff + 5'h01;
                    nxt_state = S_LOAD_RD;
                end
            end
            S_EXEC:
            begin
                unique case (func_ff)
                    FN_SETPARAM:
                    begin
                        if (wtOk(pr_ff[OFS_WTIME]) &&
                            {pr_ff[OFS_ETIME + 5'h02], pr_ff[OFS_ETIME + 5'h01],
                             pr_ff[OFS_ETIME]} != 24'h000000)
                        begin
                            nxt_wt = pr_ff[OFS_WTIME];
                            nxt_et = {pr_ff[OFS_ETIME + 5'h02],
                                      pr_ff[OFS_ETIME + 5'h01],
                                      pr_ff[OFS_ETIME]};
                        end
                        else
                        begin
                            st = ST_PARAM;
                        end
                        goStore = 1'b1;
                    end
                    FN_INFO:
                    begin
                        unique case (pr_ff[OFS_COUNT])
                            8'h00: nxt_pr[OFS_COUNT] = FW_VERSION;
                            8'h01:
                            begin
                                nxt_pr[OFS_BLOCKS] = TOTAL_BLOCKS;
                                nxt_pr[OFS_AREAS] = AREA_COUNT;
                            end
                            8'h02:
                            begin
                                nxt_pr[OFS_END] = AREA0_END[7:0];
                                nxt_pr[OFS_END + 5'h01] = AREA0_END[15:8];
                            end
                            8'h03:
                            begin
                                nxt_pr[OFS_END] = AREA1_END[7:0];
                                nxt_pr[OFS_END + 5'h01] = AREA1_END[15:8];
                            end
                            default: st = ST_PARAM;
                        endcase
                        goStore = 1'b1;
                    end
                    FN_BLANK, FN_PREWRITE, FN_ERASE, FN_VERIFY:
                    begin
                        if (pr_ff[OFS_COUNT] > 8'h01)
                        begin
                            st = ST_PARAM;
                            goStore = 1'b1;
                        end
                        else
                        begin
                            nxt_fcmd.area = pr_ff[OFS_COUNT][0];
                            nxt_fcmd.addr = 16'h0000;
                            nxt_fcmd.wdata = 8'h00;
                            nxt_fcmd.cmd = (func_ff == FN_BLANK) ? FC_BLANK :
                                (func_ff == FN_PREWRITE) ? FC_PREWRITE :
                                (func_ff == FN_ERASE) ? FC_ERASE : FC_VERIFY;
                            nxt_freq = 1'b1;
                            nxt_state = S_FL_WAIT;
                        end
                    end
                    FN_WRITE:
                    begin
                        if (lastAddr > {1'b0, AREA1_END})
                        begin
                            st = ST_PARAM;
                            goStore = 1'b1;
                        end
                        else
                        begin
                            nxt_cnt = wcnt;
                            nxt_cur = {pr_ff[OFS_START + 5'h01], pr_ff[OFS_START]};
                            nxt_buf = {pr_ff[OFS_BUF + 5'h01], pr_ff[OFS_BUF]};
                            nxt_state = S_BW_RD;
                        end
                    end
                    default:
                    begin
                        st = ST_PARAM;
                        goStore = 1'b1;
                    end
                endcase
            end
            S_BW_RD:
            begin
                nxt_ram.addr = buf_ff;
                nxt_ram.re = 1'b1;
                nxt_state = S_BW_WT;
            end
            S_BW_WT:
            begin
                nxt_state = S_BW_CAP;
            end
            S_BW_CAP:
            begin
                nxt_fcmd.cmd = FC_PROGRAM;
                nxt_fcmd.area = cur_ff[15];
                nxt_fcmd.addr = cur_ff;
                nxt_fcmd.wdata = ramRdata;
                nxt_freq = 1'b1;
                nxt_state = S_FL_WAIT;
            end
            S_FL_WAIT:
            begin
                if (flashAck)
                begin
                    nxt_freq = 1'b0;
                    if (flashErr)
                    begin
                        st = errCode(func_ff);
                        goStore = 1'b1;
                        // failed byte address left for software
                        if (func_ff == FN_WRITE)
                        begin
                            nxt_pr[OFS_START] = cur_ff[7:0];
                            nxt_pr[OFS_START + 5'h01] = cur_ff[15:8];
                        end
                    end
                    else if (func_ff == FN_WRITE)
                    begin
                        nxt_cur = endAddr;
                        nxt_buf = buf_ff + 16'h0001;
                        nxt_cnt = cnt_ff - 9'h001;
                        if (cnt_ff == 9'h001)
                        begin
                            nxt_pr[OFS_START] = endAddr[7:0];
                            nxt_pr[OFS_START + 5'h01] = endAddr[15:8];
                            goStore = 1'b1;
                        end
                        else
                        begin
                            nxt_state = S_BW_RD;
                        end
                    end
                    else
                    begin
                        goStore = 1'b1;
                    end
                end
            end
            S_STORE:
            begin
                // whole parameter block written back, unchanged bytes too
                nxt_ram.addr = base_ff + {11'h000, idx_ff};
                nxt_ram.wdata = pr_ff[idx_ff];
                nxt_ram.we = 1'b1;
                if (idx_ff == PARAM_LAST)
                begin
                    nxt_state = S_FINISH;
                end
                else
                begin
                    nxt_idx = idx_ff + 5'h01;
                end
            end
            S_FINISH:
            begin
                nxt_done = 1'b1;
                nxt_state = S_IDLE;
            end
            default:
            begin
                nxt_state = S_IDLE;
            end
        endcase
        if (goStore)
        begin
            nxt_pr[OFS_STATUS] = st;
            nxt_stat = st;
            nxt_idx = OFS_STATUS;
            nxt_state = S_STORE;
        end
        // registered so the port comes straight from a flop
        nxt_busy = (nxt_state != S_IDLE);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= S_IDLE;
            for (int i = 0; i < 18; i++)
            begin
                pr_ff[i] <= 8'h00;
            end
            idx_ff <= 5'h00;
            base_ff <= 16'h0000;
            func_ff <= 8'h00;
            cnt_ff <= 9'h000;
            cur_ff <= 16'h0000;
            buf_ff <= 16'h0000;
            stat_ff <= 8'h00;
            done_ff <= 1'b0;
            ram_ff <= '0;
            freq_ff <= 1'b0;
            fcmd_ff <= '0;
            wt_ff <= 8'h00;
            et_ff <= 24'h000000;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pr_ff <= nxt_pr;
            idx_ff <= nxt_idx;
            base_ff <= nxt_base;
            func_ff <= nxt_func;
            cnt_ff <= nxt_cnt;
            cur_ff <= nxt_cur;
            buf_ff <= nxt_buf;
            stat_ff <= nxt_stat;
            done_ff <= nxt_done;
            ram_ff <= nxt_ram;
            freq_ff <= nxt_freq;
            fcmd_ff <= nxt_fcmd;
            wt_ff <= nxt_wt;
            et_ff <= nxt_et;
            busy_ff <= nxt_busy;
        end
    end

    assign sfrRdata = rdata_ff;
    assign selfWriteMode = mode_ff[MODE_BIT];
    assign callDone = done_ff;
    assign busy = busy_ff;
    assign statusB = stat_ff;
    assign ramReq = ram_ff;
    assign flashReq = freq_ff;
    assign flashCmd = fcmd_ff;
    assign writeTime = wt_ff;
    assign eraseTime = et_ff;
endmodule : flash_self_write_control

// ---- shared/flash_sw_pkg.sv ----
// Purpose: constants and carriers for the flash self-write controller
// Assumes: byte-wide cpu special register bus, synchronous ram port
// Notes: entry area fields are little endian, low byte at lower offset
package flash_sw_pkg;
    localparam logic [15:0] MODE_CTRL_ADDR = 16'hff89;
    localparam logic [7:0] MODE_CTRL_RST = 8'h08;
    localparam int MODE_BIT = 0;
    localparam int VPP_BIT = 2;

    localparam int ENTRY_BYTES = 32;
    localparam logic [4:0] PARAM_LAST = 5'h11;
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_START = 5'h02;
    localparam logic [4:0] OFS_END = 5'h04;
    localparam logic [4:0] OFS_COUNT = 5'h06;
    localparam logic [4:0] OFS_WTIME = 5'h07;
    localparam logic [4:0] OFS_ETIME = 5'h08;
    localparam logic [4:0] OFS_BUF = 5'h0e;
    localparam logic [4:0] OFS_BLOCKS = 5'h10;
    localparam logic [4:0] OFS_AREAS = 5'h11;

    localparam logic [7:0] FN_INIT = 8'h00;
    localparam logic [7:0] FN_SETPARAM = 8'h01;
    localparam logic [7:0] FN_INFO = 8'h02;
    localparam logic [7:0] FN_BLANK = 8'h10;
    localparam logic [7:0] FN_PREWRITE = 8'h20;
    localparam logic [7:0] FN_ERASE = 8'h30;
    localparam logic [7:0] FN_WRITE = 8'h50;
    localparam logic [7:0] FN_VERIFY = 8'h60;

    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_BLANK = 8'h02;
    localparam logic [7:0] ST_WRITE = 8'h08;
    localparam logic [7:0] ST_VERIFY = 8'h10;
    localparam logic [7:0] ST_PARAM = 8'h80;

    localparam logic [15:0] AREA0_END = 16'h7fff;
    localparam logic [15:0] AREA1_END = 16'hefff;
    localparam logic [7:0] AREA_COUNT = 8'h02;
    localparam logic [8:0] MAX_WRITE_BYTES = 9'h100;

    localparam logic [7:0] WT_1M28 = 8'h20;
    localparam logic [7:0] WT_2M56 = 8'h40;
    localparam logic [7:0] WT_5M12 = 8'h60;
    localparam logic [7:0] WT_8M38 = 8'h80;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_LOAD_RD = 4'h1,
        S_LOAD_WT = 4'h2,
        S_LOAD_CAP = 4'h3,
        S_EXEC = 4'h4,
        S_FL_WAIT = 4'h5,
        S_BW_RD = 4'h6,
        S_BW_WT = 4'h7,
        S_BW_CAP = 4'h8,
        S_STORE = 4'h9,
        S_FINISH = 4'ha
    } seq_state_e;

    typedef enum logic [2:0] {
        FC_NONE = 3'h0,
        FC_BLANK = 3'h1,
        FC_PREWRITE = 3'h2,
        FC_ERASE = 3'h3,
        FC_VERIFY = 3'h4,
        FC_PROGRAM = 3'h5
    } flash_cmd_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic bitWr;
        logic [2:0] bitSel;
        logic rd;
    } sfr_bus_s;

    typedef struct packed {
        flash_cmd_e cmd;
        logic area;
        logic [15:0] addr;
        logic [7:0] wdata;
    } flash_req_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } ram_req_s;
endpackage : flash_sw_pkg
